// ==== core/pdb_top.sv ====
// module: pwm auto-restart, shutdown handling and dead-band output stage
//
// Notes on behaviour
// - auto-restart only when restart_enable bit 7 set
// - with restart, flag held while condition active
// - with restart, hardware clears flag, output resumes
// - without restart, shutdown held until software clears
// - dead band only on inactive-to-active edges
// - delay is bits 6..0 instruction cycles
// - delay from scheduled to actual active edge
// - event sets flag, forces outputs to shutdown states
// - shutdown condition is a level, not edge
// - restart only at next pwm period start
// - flag writes ignored while condition persists
//
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module pdb_top #(
	parameter int CW = pdb_pkg::DB_COUNT_W
) (
	input  wire logic        ref_clk,
	input  wire logic        rstn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// shutdown sources, both asynchronous
	input  wire logic        shutdownPinN,  // low level requests shutdown
	input  wire logic        comparatorIn,  // high level requests shutdown
	// pwm timing from the unit, same clock
	input  wire logic        pwmSched,      // scheduled half-bridge level
	input  wire logic        periodStart,   // one-cycle pulse per period
	input  wire logic        halfBridgeEn,  // half-bridge mode select
	// half-bridge outputs, oe high while driven
	output logic             pwm_out_a,
	output logic             pwm_out_a_oe,
	output logic             pwm_out_b,
	output logic             pwm_out_b_oe,
	output logic             irq
);

	// ****************************************************************
	// state and helpers
	// ****************************************************************
	pdb_pkg::pdb_top_type st_r;   // registered state
	pdb_pkg::pdb_top_type st_nxt; // next state
	logic          [1:0] dbAct;   // dead-band outputs, a then b
	logic          [1:0] dbSched; // scheduled levels, a then b
	logic       [CW-1:0] dbCount; // effective delay
	logic                cond;    // live shutdown condition
	logic                wrAcc;   // write access phase
	logic                wrSd;    // write to shutdown_control
	logic          [2:0] src;     // shutdown_source_select

	// source select: bit 0 comparator, bit 1 comparator, bit 2 pin;
	// 000 disables every hardware source
	assign src  = st_r.sdCtrl[pdb_pkg::SD_SRC_LSB +: 3];
	assign cond = ((src[0] | src[1]) & st_r.cmpSync[1])
		| (src[2] & ~st_r.intSync[1]);
	assign wrAcc = psel & penable & pwrite;
	assign wrSd  = wrAcc && (paddr == pdb_pkg::SD_CTRL_ADDR);

	// outside half-bridge mode the outputs pass with no dead band
	assign dbCount = halfBridgeEn
		? st_r.dbCtrl[CW-1:0] : '0;
	assign dbSched = {~pwmSched, pwmSched};

	// ****************************************************************
	// dead-band delay, one per output
	// ****************************************************************
	for (genvar g = 0; g < 2; g++) begin : gDb
		pdb_dead_band #(
			.CW     (CW)
		) uDb (
			.ref_clk(ref_clk),
			.rstn   (rstn),
			.tick   (st_r.instrTick),
			.count  (dbCount),
			.sched  (dbSched[g]),
			.active (dbAct[g])
		);
	end

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		logic [1:0] ev;     // events raised this cycle
		logic [1:0] aSt;    // out_a_shutdown_state
		logic [1:0] bSt;    // out_b_shutdown_state
		logic       flag;   // flag after this cycle
		ev     = 2'b00;
		aSt    = 2'b00;
		bSt    = 2'b00;
		flag   = 1'b0;
		st_nxt = st_r;

		// two-flop synchronisers, only the second flop is read
		st_nxt.intSync = {st_r.intSync[0], shutdownPinN};
		st_nxt.cmpSync = {st_r.cmpSync[0], comparatorIn};

		// divider: one enable pulse per instruction_cycle
		st_nxt.instrTick = (st_r.divCnt == pdb_pkg::INSTR_DIV_LAST);
		st_nxt.divCnt = st_nxt.instrTick ? 2'h0 : st_r.divCnt + 2'h1;

		// register writes in the access phase
		if (wrAcc) begin
			if (paddr == pdb_pkg::SD_CTRL_ADDR) begin
				// flag bit handled below, others stored as written
				st_nxt.sdCtrl[6:0] = pwdata[6:0];
			end else if (paddr == pdb_pkg::DB_CTRL_ADDR) begin
				st_nxt.dbCtrl = pwdata[7:0];
			end else if (paddr == pdb_pkg::IRQ_STAT_ADDR) begin
				st_nxt.irqStat = st_r.irqStat
					& ~pwdata[pdb_pkg::IRQ_W-1:0];
			end else if (paddr == pdb_pkg::IRQ_MASK_ADDR) begin
				st_nxt.irqMask = pwdata[pdb_pkg::IRQ_W-1:0];
			end
		end

		// shutdown_event_flag: condition wins, then restart, then software
		flag = st_r.sdCtrl[pdb_pkg::SD_FLAG_BIT];
		if (cond) begin
			// set and held while the level lasts, writes ignored
			flag = 1'b1;
		end else if (st_r.dbCtrl[pdb_pkg::DB_RESTART_BIT]) begin
			// condition gone: hardware clears the flag
			flag = 1'b0;
			if (wrSd && pwdata[pdb_pkg::SD_FLAG_BIT]) begin
				flag = 1'b1; // software-raised event
			end
		end else if (wrSd) begin
			// without restart only software moves the flag
			flag = pwdata[pdb_pkg::SD_FLAG_BIT];
		end
		st_nxt.sdCtrl[pdb_pkg::SD_FLAG_BIT] = flag;

		// output run state
		case (st_r.run)
			pdb_pkg::RUN_ON: begin
				if (flag) begin
					st_nxt.run = pdb_pkg::RUN_OFF;
					ev[pdb_pkg::IRQ_SHUT_BIT] = 1'b1;
				end
			end
			pdb_pkg::RUN_OFF: begin
				if (!flag) begin
					st_nxt.run = pdb_pkg::RUN_WAIT;
				end
			end
			pdb_pkg::RUN_WAIT: begin
				if (flag) begin
					st_nxt.run = pdb_pkg::RUN_OFF;
				end else if (periodStart) begin
					// resume only on a period boundary
					st_nxt.run = pdb_pkg::RUN_ON;
					ev[pdb_pkg::IRQ_RESUME_BIT] = 1'b1;
				end
			end
			default: begin
				st_nxt.run = pdb_pkg::RUN_OFF;
			end
		endcase

		// sticky events: a set in the clearing cycle wins
		st_nxt.irqStat = st_nxt.irqStat | ev;

		// pins: forced from the cycle the flag rises until run is RUN_ON again, else dead-band output
		aSt = st_r.sdCtrl[pdb_pkg::SD_A_STATE_LSB +: 2];
		bSt = st_r.sdCtrl[pdb_pkg::SD_B_STATE_LSB +: 2];
		if (flag || st_nxt.run != pdb_pkg::RUN_ON) begin
			// 00 drive low, 01 drive high, 1x released
			st_nxt.outA = aSt[0] & ~aSt[1];
			st_nxt.oeA  = ~aSt[1];
			st_nxt.outB = bSt[0] & ~bSt[1];
			st_nxt.oeB  = ~bSt[1];
		end else begin
			st_nxt.outA = dbAct[0];
			st_nxt.oeA  = 1'b1;
			st_nxt.outB = dbAct[1];
			st_nxt.oeB  = 1'b1;
		end

		// read data captured in the setup phase, answered next cycle
		if (psel && !penable) begin
			st_nxt.rdata  = 32'h0000_0000;
			st_nxt.slvErr = 1'b0;
			if (paddr == pdb_pkg::SD_CTRL_ADDR) begin
				st_nxt.rdata[7:0] = st_r.sdCtrl;
			end else if (paddr == pdb_pkg::DB_CTRL_ADDR) begin
				st_nxt.rdata[7:0] = st_r.dbCtrl;
			end else if (paddr == pdb_pkg::IRQ_STAT_ADDR) begin
				st_nxt.rdata[pdb_pkg::IRQ_W-1:0] = st_r.irqStat;
			end else if (paddr == pdb_pkg::IRQ_MASK_ADDR) begin
				st_nxt.rdata[pdb_pkg::IRQ_W-1:0] = st_r.irqMask;
			end else begin
				st_nxt.slvErr = 1'b1;
			end
		end
	end

	// ****************************************************************
	// state register
	// ****************************************************************
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			st_r         <= '0;
			st_r.intSync <= 2'b11;
			st_r.sdCtrl  <= pdb_pkg::SD_CTRL_RST;
			st_r.dbCtrl  <= pdb_pkg::DB_CTRL_RST;
			st_r.irqStat <= pdb_pkg::IRQ_RST;
			st_r.irqMask <= pdb_pkg::IRQ_RST;
			st_r.run     <= pdb_pkg::RUN_ON;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign pready       = 1'b1; // no wait states
	assign prdata       = st_r.rdata;
	assign pslverr      = st_r.slvErr & psel & penable;
	assign pwm_out_a    = st_r.outA;
	assign pwm_out_a_oe = st_r.oeA;
	assign pwm_out_b    = st_r.outB;
	assign pwm_out_b_oe = st_r.oeB;
	assign irq          = |(st_r.irqStat & st_r.irqMask);

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	flag_on_cond_a : assert property (
		cond |=> st_r.sdCtrl[pdb_pkg::SD_FLAG_BIT])
		else $error("flag not set by shutdown condition");
	flag_held_a : assert property (
		(cond && st_r.dbCtrl[pdb_pkg::DB_RESTART_BIT]) [*2]
		|=> st_r.sdCtrl[pdb_pkg::SD_FLAG_BIT])
		else $error("flag dropped while condition active");
	auto_clear_a : assert property (
		(!cond && st_r.dbCtrl[pdb_pkg::DB_RESTART_BIT] && !wrSd)
		|=> !st_r.sdCtrl[pdb_pkg::SD_FLAG_BIT])
		else $error("flag not cleared by auto-restart");
	no_restart_a : assert property (
		(st_r.sdCtrl[pdb_pkg::SD_FLAG_BIT] && !wrSd
		&& !st_r.dbCtrl[pdb_pkg::DB_RESTART_BIT])
		|=> st_r.sdCtrl[pdb_pkg::SD_FLAG_BIT])
		else $error("flag cleared without software");
	write_ignored_a : assert property (
		(cond && wrSd && !pwdata[pdb_pkg::SD_FLAG_BIT])
		|=> st_r.sdCtrl[pdb_pkg::SD_FLAG_BIT])
		else $error("flag write accepted during shutdown");
	period_resume_a : assert property (
		(st_r.run == pdb_pkg::RUN_WAIT && !periodStart)
		|=> st_r.run != pdb_pkg::RUN_ON)
		else $error("output resumed off a period start");
	forced_pins_a : assert property (
		(st_r.run == pdb_pkg::RUN_OFF
		&& st_r.sdCtrl[pdb_pkg::SD_A_STATE_LSB +: 2] == 2'b01)
		|=> (pwm_out_a && pwm_out_a_oe))
		else $error("out a not in its shutdown state");
	tick_period_a : assert property (
		st_r.instrTick |=> !st_r.instrTick [*3] ##1 st_r.instrTick)
		else $error("instruction cycle enable not every 4 clocks");

endmodule : pdb_top

// ==== inc/pdb_pkg.sv ====
// package: register map, field layout, reset values and timing of the pwm block
package pdb_pkg;

	// ****************************************************************
	// register byte addresses on the apb bus
	// ****************************************************************
	localparam logic [7:0] SD_CTRL_ADDR   = 8'h00; // shutdown_control
	localparam logic [7:0] DB_CTRL_ADDR   = 8'h04; // dead_band_restart_control
	localparam logic [7:0] IRQ_STAT_ADDR  = 8'h08; // sticky event bits, w1c
	localparam logic [7:0] IRQ_MASK_ADDR  = 8'h0C; // event enables

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int SD_FLAG_BIT    = 7; // shutdown_event_flag
	localparam int SD_SRC_LSB     = 4; // shutdown_source_select, 3 bits
	localparam int SD_A_STATE_LSB = 2; // out_a_shutdown_state, 2 bits
	localparam int SD_B_STATE_LSB = 0; // out_b_shutdown_state, 2 bits
	localparam int DB_RESTART_BIT = 7; // restart_enable
	localparam int DB_COUNT_W     = 7; // dead_band_count, bits 6..0
	localparam int IRQ_SHUT_BIT   = 0; // shutdown entered
	localparam int IRQ_RESUME_BIT = 1; // output resumed
	localparam int IRQ_W          = 2;

	// ****************************************************************
	// values after reset
	// ****************************************************************
	localparam logic [7:0] SD_CTRL_RST = 8'h00;
	localparam logic [7:0] DB_CTRL_RST = 8'h00;
	localparam logic [1:0] IRQ_RST     = 2'h0;

	// ****************************************************************
	// timing: one instruction_cycle is four oscillator periods
	// ****************************************************************
	localparam int CLK_PERIOD_PS   = 5000; // ref_clk at 200 MHz
	localparam int INSTR_TOSC      = 4;    // oscillator periods per cycle
	localparam int INSTR_PERIOD_PS = INSTR_TOSC * CLK_PERIOD_PS;
	localparam int INSTR_CLKS      = INSTR_PERIOD_PS / CLK_PERIOD_PS;
	localparam logic [1:0] INSTR_DIV_LAST = 2'(INSTR_CLKS - 1);

	// ****************************************************************
	// types
	// ****************************************************************
	typedef enum logic [1:0] {
		RUN_ON   = 2'b00, // outputs follow the pwm
		RUN_OFF  = 2'b01, // outputs forced, flag set
		RUN_WAIT = 2'b10  // flag clear, waiting for next period start
	} pdb_run_type;

	typedef struct packed {
		logic [1:0]  intSync;   // shutdown pin synchroniser
		logic [1:0]  cmpSync;   // comparator synchroniser
		logic [7:0]  sdCtrl;    // shutdown_control
		logic [7:0]  dbCtrl;    // dead_band_restart_control
		logic [1:0]  irqStat;   // sticky events
		logic [1:0]  irqMask;   // event enables
		logic [1:0]  divCnt;    // instruction cycle divider
		logic        instrTick; // one-cycle enable per instruction_cycle
		pdb_run_type run;       // output run state
		logic        outA;      // pwm_out_a level
		logic        oeA;       // pwm_out_a enable
		logic        outB;      // pwm_out_b level
		logic        oeB;       // pwm_out_b enable
		logic [31:0] rdata;     // apb read data
		logic        slvErr;    // apb error for unmapped address
	} pdb_top_type;

	typedef struct packed {
		logic                  act; // delayed active output
		logic [DB_COUNT_W-1:0] cnt; // elapsed instruction cycles
	} pdb_db_type;

endpackage : pdb_pkg

// ==== core/pdb_dead_band.sv ====
// module: dead-band delay of one output's inactive-to-active edge
`timescale 1ns/1ps
module pdb_dead_band #(
	parameter int CW = 7
) (
	input  wire logic          ref_clk,
	input  wire logic          rstn,
	input  wire logic          tick,     // instruction_cycle enable
	input  wire logic [CW-1:0] count,    // delay in instruction cycles
	input  wire logic          sched,    // scheduled active level
	output logic               active    // delayed active level
);

	// ****************************************************************
	// state
	// ****************************************************************
	pdb_pkg::pdb_db_type st_r; // registered state
	pdb_pkg::pdb_db_type st_nxt; // next state

	// deactivation is immediate, activation waits count ticks
	always_comb begin
		st_nxt = st_r;
		if (!sched) begin
			// going inactive is never delayed
			st_nxt.act = 1'b0;
			st_nxt.cnt = '0;
		end else if (!st_r.act) begin
			// delay measured from scheduled edge to real edge
			if (st_r.cnt >= count) begin
				st_nxt.act = 1'b1;
			end else if (tick) begin
				st_nxt.cnt = st_r.cnt + CW'(1);
			end
		end
	end

	// register the state
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign active = st_r.act;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	fall_no_delay_a : assert property (
		!sched |=> !active)
		else $error("active stayed high after schedule fell");
	zero_no_delay_a : assert property (
		(count == '0 && sched && !active) |=> active)
		else $error("zero count delayed the active edge");
	rise_waits_a : assert property (
		($rose(sched) && count != '0) |=> !active)
		else $error("active edge not delayed");

endmodule : pdb_dead_band

// ==== sim/pdb_half_bridge.sv ====
// model: half-bridge power switches driven by the two pwm outputs
`timescale 1ns/1ps
module pdb_half_bridge (
	input  wire logic ref_clk,
	input  wire logic rstn,
	input  wire logic gateA,    // upper switch gate
	input  wire logic gateAOe,  // upper gate driven
	input  wire logic gateB,    // lower switch gate
	input  wire logic gateBOe,  // lower gate driven
	output int        overlaps  // cycles with both switches on
);
	// ****************************************************************
	// switch state
	// ****************************************************************
	logic onA; // a released gate falls to its pull-down, so the switch is off
	logic onB;
	assign onA = gateAOe & (gateA === 1'b1);
	assign onB = gateBOe & (gateB === 1'b1);
	// both on together would short the supply; count each such cycle
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			overlaps <= 0;
		end else if (onA && onB) begin
			overlaps <= overlaps + 1;
		end
	end
endmodule : pdb_half_bridge

// ==== sim/pdb_top_tb.sv ====
// testbench: registers, dead band, shutdown and restart of the pwm block
`timescale 1ns/1ps
module pdb_top_tb;
	// ****************************************************************
	// stimulus and observed signals
	// ****************************************************************
	logic        ref_clk = 0, rstn = 0;
	logic        psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic        pready, pslverr, pwm_out_a, pwm_out_a_oe;
	logic        pwm_out_b, pwm_out_b_oe, irq, lastErr;
	logic [31:0] prdata, rd;
	logic        shutdownPinN = 1, comparatorIn = 0;
	logic        pwmSched = 0, periodStart = 0, halfBridgeEn = 1;
	int          failures = 0, nTests = 0, cycles = 0, c, overlaps;

	pdb_top uut (.ref_clk(ref_clk), .rstn(rstn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr),
		.shutdownPinN(shutdownPinN), .comparatorIn(comparatorIn),
		.pwmSched(pwmSched), .periodStart(periodStart),
		.halfBridgeEn(halfBridgeEn), .pwm_out_a(pwm_out_a),
		.pwm_out_a_oe(pwm_out_a_oe), .pwm_out_b(pwm_out_b),
		.pwm_out_b_oe(pwm_out_b_oe), .irq(irq));
	pdb_half_bridge bridge (.ref_clk(ref_clk), .rstn(rstn),
		.gateA(pwm_out_a), .gateAOe(pwm_out_a_oe), .gateB(pwm_out_b),
		.gateBOe(pwm_out_b_oe), .overlaps(overlaps));

	always #2.5 ref_clk = ~ref_clk; // 200 MHz

	// ****************************************************************
	// shared tasks
	// ****************************************************************
	task automatic report_and_stop();
		if (failures == 0 && nTests > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : report_and_stop

	// the whole run is a few hundred cycles; a hang ends here
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures++;
			report_and_stop();
		end
	end

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		nTests++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// apb transfer; request held until pready is seen high at an edge
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge ref_clk);
		psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
		@(posedge ref_clk);
		penable <= 1;
		// if pready never rises, only the bench timeout ends this wait
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		q = prdata;
		lastErr = pslverr;
		psel <= 0; penable <= 0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		apb(1'b1, a, d, q);
	endtask : wr

	task automatic pulse_period();
		@(posedge ref_clk) periodStart <= 1;
		@(posedge ref_clk) periodStart <= 0;
		repeat (3) @(posedge ref_clk);
	endtask : pulse_period

	// edges from a change of the scheduled level until a pin shows exp
	task automatic edge_delay(input bit drive, input logic lvl, input bit useB,
		input logic exp, output int n);
		if (drive) @(posedge ref_clk) pwmSched <= lvl;
		n = 0;
		do begin
			@(posedge ref_clk);
			#1 n++;
		end while (((useB ? pwm_out_b : pwm_out_a) !== exp) && n < 600);
	endtask : edge_delay

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic test_registers();
		apb(0, pdb_pkg::SD_CTRL_ADDR, 0, rd); chk("sd ctrl reset", 0, rd);
		apb(0, pdb_pkg::DB_CTRL_ADDR, 0, rd); chk("db ctrl reset", 0, rd);
		apb(0, pdb_pkg::IRQ_STAT_ADDR, 0, rd); chk("irq stat reset", 0, rd);
		apb(0, 8'h10, 0, rd); chk("unmapped error", 1, 32'(lastErr));
		wr(pdb_pkg::DB_CTRL_ADDR, 32'h0000_00FF);
		apb(0, pdb_pkg::DB_CTRL_ADDR, 0, rd); chk("db ctrl rw", 32'hFF, rd);
	endtask : test_registers

	task automatic test_dead_band();
		wr(pdb_pkg::DB_CTRL_ADDR, 32'h0000_0003); // three instruction cycles
		repeat (20) @(posedge ref_clk);
		edge_delay(1, 1, 0, 1, c);
		chk("a rise delay ok", 1, 32'(c >= 10 && c <= 14));
		chk("b off before a on", 0, 32'(pwm_out_b));
		repeat (20) @(posedge ref_clk);
		edge_delay(1, 0, 0, 0, c); chk("a fall delay", 2, c);
		edge_delay(0, 0, 1, 1, c);
		chk("b rise delay ok", 1, 32'(c >= 8 && c <= 12));
		wr(pdb_pkg::DB_CTRL_ADDR, 32'h0000_0000);
		repeat (10) @(posedge ref_clk);
		edge_delay(1, 1, 0, 1, c); chk("zero count delay", 2, c);
		wr(pdb_pkg::DB_CTRL_ADDR, 32'h0000_0003);
		halfBridgeEn <= 0;
		edge_delay(1, 0, 1, 1, c); chk("no half bridge delay", 2, c);
		halfBridgeEn <= 1;
		edge_delay(1, 0, 1, 1, c);
		chk("shoot through cycles", 0, overlaps);
	endtask : test_dead_band

	task automatic test_auto_restart();
		wr(pdb_pkg::DB_CTRL_ADDR, 32'h0000_0080); // restart on, count 0
		wr(pdb_pkg::IRQ_MASK_ADDR, 32'h0000_0003);
		wr(pdb_pkg::SD_CTRL_ADDR, 32'h0000_0044); // pin source, a=1, b=0
		shutdownPinN <= 0;
		repeat (6) @(posedge ref_clk);
		chk("a forced", 1, 32'(pwm_out_a));
		chk("a driven", 1, 32'(pwm_out_a_oe));
		chk("b forced", 0, 32'(pwm_out_b));
		chk("irq on entry", 1, 32'(irq));
		wr(pdb_pkg::SD_CTRL_ADDR, 32'h0000_0044);
		repeat (20) @(posedge ref_clk);
		apb(0, pdb_pkg::SD_CTRL_ADDR, 0, rd);
		chk("flag held", 32'hC4, rd);
		shutdownPinN <= 1;
		repeat (8) @(posedge ref_clk);
		apb(0, pdb_pkg::SD_CTRL_ADDR, 0, rd);
		chk("flag auto clear", 32'h44, rd);
		chk("a held to period", 1, 32'(pwm_out_a));
		pulse_period();
		chk("a resumed", 0, 32'(pwm_out_a));
		chk("b resumed", 1, 32'(pwm_out_b));
		apb(0, pdb_pkg::IRQ_STAT_ADDR, 0, rd); chk("irq events", 3, rd);
		wr(pdb_pkg::IRQ_STAT_ADDR, 32'h0000_0003);
		// the clear lands at the access edge; look once it has settled
		@(posedge ref_clk);
		chk("irq cleared", 0, 32'(irq));
	endtask : test_auto_restart

	task automatic test_manual_restart();
		wr(pdb_pkg::IRQ_MASK_ADDR, 32'h0000_0000);
		wr(pdb_pkg::DB_CTRL_ADDR, 32'h0000_0000); // restart off
		wr(pdb_pkg::SD_CTRL_ADDR, 32'h0000_0016); // comparator, b released
		comparatorIn <= 1;
		repeat (6) @(posedge ref_clk);
		chk("a forced high", 1, 32'(pwm_out_a));
		chk("b released", 0, 32'(pwm_out_b_oe));
		comparatorIn <= 0;
		repeat (8) @(posedge ref_clk);
		pulse_period();
		apb(0, pdb_pkg::SD_CTRL_ADDR, 0, rd);
		chk("flag kept", 32'h96, rd);
		chk("still shut", 1, 32'(pwm_out_a));
		chk("irq masked", 0, 32'(irq));
		wr(pdb_pkg::SD_CTRL_ADDR, 32'h0000_0016);
		repeat (4) @(posedge ref_clk);
		chk("wait for period", 1, 32'(pwm_out_a));
		pulse_period();
		chk("a after clear", 0, 32'(pwm_out_a));
		chk("b driven again", 1, 32'(pwm_out_b_oe));
	endtask : test_manual_restart

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		repeat (20) @(posedge ref_clk);
		rstn <= 1;
		test_registers();
		test_dead_band();
		pwmSched <= 0;
		repeat (20) @(posedge ref_clk);
		test_auto_restart();
		test_manual_restart();
		chk("no overlap", 0, overlaps);
		report_and_stop();
	end
endmodule : pdb_top_tb
